// file: shared/cwas_pkg.sv
// shared constants for the charger two-wire word access port
package cwas_pkg;
  // full 8-bit address with write direction, 7-bit form derived
  localparam logic [7:0] CWAS_ADDR8      = 8'hD6;
  localparam logic [6:0] CWAS_ADDR7      = CWAS_ADDR8[7:1];
  // register byte offsets
  localparam logic [7:0] CWAS_OFS_OPT0_L = 8'h00;
  localparam logic [7:0] CWAS_OFS_OPT0_H = 8'h01;
  localparam logic [7:0] CWAS_OFS_ICHG_L = 8'h02;
  localparam logic [7:0] CWAS_OFS_ICHG_H = 8'h03;
  localparam logic [7:0] CWAS_OFS_VLIM_L = 8'h04;
  localparam logic [7:0] CWAS_OFS_VLIM_H = 8'h05;
  localparam logic [7:0] CWAS_OFS_MAKER  = 8'h2E;
  localparam logic [7:0] CWAS_OFS_PART   = 8'h2F;
  // arbitrary identification values
  localparam logic [7:0] CWAS_MAKER_VAL  = 8'h5A;
  localparam logic [7:0] CWAS_PART_VAL   = 8'hA5;
  // reset values
  localparam logic [15:0] CWAS_OPT0_RST  = 16'hE70E;
  localparam logic [15:0] CWAS_ICHG_RST  = 16'h0000;
  localparam logic [15:0] CWAS_VLIM_RST  = 16'h0000;
  // watchdog option field position in the option 0 word (high byte 6:5)
  localparam int          CWAS_WDT_LSB   = 13;
  // watchdog default time in seconds and clock rate
  localparam longint      CWAS_WDT_S     = 175;
  localparam longint      CWAS_CLK_HZ    = 200_000_000;
  localparam longint      CWAS_WDT_CYC   = CWAS_WDT_S * CWAS_CLK_HZ;
  // host command/status register byte addresses (AXI4-Lite)
  localparam logic [3:0]  CWAS_AX_CMD    = 4'h0;
  localparam logic [3:0]  CWAS_AX_STAT   = 4'h4;
  localparam logic [3:0]  CWAS_AX_RDAT   = 4'h8;
  localparam logic [3:0]  CWAS_AX_DIV    = 4'hC;
  // bus quarter-period default: 200 MHz / (4*125) = 400 kHz
  localparam logic [15:0] CWAS_DIV_RST   = 16'h007D;
endpackage : cwas_pkg

// file: shared/cwas_if.sv
// open-drain two-wire bus joining the host and the device end
`timescale 1ns/10ps
interface cwas_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_o_host;
  logic sda_oe_host;
  logic scl_o_dev;
  logic scl_oe_dev;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled low driver wins
  assign scl = !((scl_oe_host && !scl_o_host) || (scl_oe_dev && !scl_o_dev));
  assign sda = !((sda_oe_host && !sda_o_host) || (sda_oe_dev && !sda_o_dev));
  modport host (output scl_o_host, scl_oe_host, sda_o_host, sda_oe_host,
                input scl, sda);
  modport dev  (output scl_o_dev, scl_oe_dev, sda_o_dev, sda_oe_dev,
                input scl, sda);
endinterface : cwas_if

// file: logic/cwas_dev.sv
// device end: two-wire slave with atomic two-byte commit of the charge current and voltage limit words
//
// Notes on behaviour
// - answer only at address D6h
// - serves standard and fast bit rates
// - data changes only while clock low
// - master makes START/STOP, slave detects both
// - busy from START until STOP
// - eight bits MSB first, then acknowledge
// - slave may stretch clock; master waits
// - master generates every clock pulse
// - receiver pulls data low during acknowledge
// - high acknowledge means NACK; then STOP/START
// - first byte: 7-bit address plus direction
// - undefined register address gets NACK, idle
// - word write and word read accepted
// - unlimited consecutive bytes per transfer; writes are NACKed once the offset reaches an undefined register
// - host writes low byte then high byte
// - low byte pending; both halves commit together (option 0 bytes are written one at a time)
// - high byte without low byte ignored
// - gap beyond watchdog discards both bytes
// - maker code fixed; part code identifies
// - pins are open-drain only
// - watchdog default 175 s, two-bit option
`timescale 1ns/10ps
module cwas_dev
  import cwas_pkg::*;
#(
  parameter longint WDT_CYCLES = CWAS_WDT_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  cwas_if.dev              BUS,
  output logic [15:0]      CHARGE_CURRENT,
  output logic [15:0]      VOLTAGE_LIMIT,
  output logic             BUS_BUSY
);
  // scaled watchdog options need at least one cycle per option unit
  if (WDT_CYCLES < 175) begin : g_wdt_check
    $error("watchdog count too small for option scaling");
  end

  typedef enum logic [2:0] {
    CWAS_S_IDLE = 3'b000,
    CWAS_S_ADDR = 3'b001,
    CWAS_S_REG  = 3'b010,
    CWAS_S_WR   = 3'b011,
    CWAS_S_RD   = 3'b100,
    CWAS_S_ACK  = 3'b101,
    CWAS_S_RACK = 3'b110,
    CWAS_S_SKIP = 3'b111
  } cwas_dstate_t;

  // defined register offsets
  function automatic logic reg_defined(input logic [7:0] a);
    reg_defined = (a <= CWAS_OFS_VLIM_H) || (a == CWAS_OFS_MAKER) ||
                  (a == CWAS_OFS_PART);
  endfunction

  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_q, sda_q;
  cwas_dstate_t st_q, ret_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q, ptr_q, tx_q;
  logic       ack_q, sda_low_q, phase_q, busy_q;
  logic [15:0] opt0_q, ichg_q, vlim_q;
  logic [7:0] pend_q;
  logic [7:0] pend_ofs_q;
  logic       pend_v_q;
  logic [63:0] wdt_q;

  // two-flop synchronisers serve both bit rates
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], BUS.scl};
      sda_s_q <= {sda_s_q[0], BUS.sda};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  logic scl_now, sda_now, scl_rise, scl_fall, start_c, stop_c;
  assign scl_now  = scl_s_q[1];
  assign sda_now  = sda_s_q[1];
  assign scl_rise = scl_now && !scl_q;
  assign scl_fall = !scl_now && scl_q;
  assign start_c  = scl_now && scl_q && sda_q && !sda_now;
  assign stop_c   = scl_now && scl_q && !sda_q && sda_now;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) busy_q <= 1'b0;
    else if (start_c) busy_q <= 1'b1;
    else if (stop_c) busy_q <= 1'b0;
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == CWAS_OFS_OPT0_L) rd_byte = opt0_q[7:0];
    else if (ptr_q == CWAS_OFS_OPT0_H) rd_byte = opt0_q[15:8];
    else if (ptr_q == CWAS_OFS_ICHG_L) rd_byte = ichg_q[7:0];
    else if (ptr_q == CWAS_OFS_ICHG_H) rd_byte = ichg_q[15:8];
    else if (ptr_q == CWAS_OFS_VLIM_L) rd_byte = vlim_q[7:0];
    else if (ptr_q == CWAS_OFS_VLIM_H) rd_byte = vlim_q[15:8];
    else if (ptr_q == CWAS_OFS_MAKER) rd_byte = CWAS_MAKER_VAL;
    else if (ptr_q == CWAS_OFS_PART) rd_byte = CWAS_PART_VAL;
  end

  logic wr_stb;
  logic [7:0] wr_ofs, wr_dat;
  // acknowledge decision for the byte just shifted in
  logic ack_now;
  assign ack_now = (st_q == CWAS_S_ADDR) ? (sh_q[7:1] == CWAS_ADDR7) :
                   (st_q == CWAS_S_REG)  ? reg_defined(sh_q) :
                   reg_defined(ptr_q);
  // protocol engine; sampling at clock rise, driving at clock fall
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= CWAS_S_IDLE;
      ret_q <= CWAS_S_IDLE;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
      phase_q <= 1'b0;
      wr_stb <= 1'b0;
      wr_ofs <= 8'h00;
      wr_dat <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        st_q <= CWAS_S_ADDR;
        bit_q <= 3'd0;
        phase_q <= 1'b0;
        sda_low_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= CWAS_S_IDLE;
        sda_low_q <= 1'b0;
      end else begin
        case (st_q)
          CWAS_S_ADDR, CWAS_S_REG, CWAS_S_WR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_now};
              bit_q <= bit_q + 3'd1;
            end else if (scl_fall && bit_q == 3'd0 && phase_q) begin
              phase_q <= 1'b0;
              ack_q <= 1'b0;
              if (st_q == CWAS_S_ADDR) begin
                ack_q <= (sh_q[7:1] == CWAS_ADDR7);
                ret_q <= !(sh_q[7:1] == CWAS_ADDR7) ? CWAS_S_SKIP :
                         sh_q[0] ? CWAS_S_RD : CWAS_S_REG;
                tx_q <= rd_byte;
              end else if (st_q == CWAS_S_REG) begin
                ack_q <= reg_defined(sh_q);
                ptr_q <= sh_q;
                ret_q <= reg_defined(sh_q) ? CWAS_S_WR : CWAS_S_SKIP;
              end else begin
                ack_q <= reg_defined(ptr_q);
                wr_stb <= reg_defined(ptr_q);
                wr_ofs <= ptr_q;
                wr_dat <= sh_q;
                ptr_q <= ptr_q + 8'd1;
                ret_q <= reg_defined(ptr_q) ? CWAS_S_WR : CWAS_S_SKIP;
              end
              st_q <= CWAS_S_ACK;
            end
            if (scl_rise && bit_q == 3'd7) phase_q <= 1'b1;
            if (scl_fall && bit_q == 3'd0 && phase_q) sda_low_q <= ack_now;
          end
          CWAS_S_ACK: begin
            if (scl_fall) begin
              sda_low_q <= 1'b0;
              bit_q <= 3'd0;
              st_q <= ack_q ? ret_q : CWAS_S_SKIP;
              if (ack_q && ret_q == CWAS_S_RD) sda_low_q <= !tx_q[7];
            end
          end
          CWAS_S_RD: begin
            // change data only on clock fall
            if (scl_fall) begin
              if (bit_q == 3'd0 && phase_q) begin
                phase_q <= 1'b0;
                sda_low_q <= 1'b0;
                st_q <= CWAS_S_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b1};
                sda_low_q <= !tx_q[6];
              end
            end
            if (scl_rise) begin
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) phase_q <= 1'b1;
            end
          end
          CWAS_S_RACK: begin
            if (scl_rise) begin
              if (sda_now) st_q <= CWAS_S_SKIP;
              else ptr_q <= ptr_q + 8'd1;
            end
            if (scl_fall && st_q == CWAS_S_RACK) begin
              tx_q <= rd_byte;
              sda_low_q <= !rd_byte[7];
              bit_q <= 3'd0;
              st_q <= CWAS_S_RD;
            end
          end
          default: sda_low_q <= 1'b0;
        endcase
      end
    end
  end

  // clock never held: every byte is served at once
  // open-drain pins, never drive high, no stretching needed
  assign BUS.sda_o_dev  = 1'b0;
  assign BUS.sda_oe_dev = sda_low_q;
  assign BUS.scl_o_dev  = 1'b0;
  assign BUS.scl_oe_dev = 1'b0;

  // watchdog limit from option field: 00 off
  logic [63:0] wdt_lim;
  always_comb begin
    case (opt0_q[CWAS_WDT_LSB+1 -: 2])
      2'b00:   wdt_lim = 64'hFFFF_FFFF_FFFF_FFFF;
      2'b01:   wdt_lim = 64'(WDT_CYCLES / 175 * 5);
      2'b10:   wdt_lim = 64'(WDT_CYCLES / 175 * 88);
      default: wdt_lim = 64'(WDT_CYCLES);
    endcase
  end

  // pending low byte and atomic commit
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      opt0_q <= CWAS_OPT0_RST;
      ichg_q <= CWAS_ICHG_RST;
      vlim_q <= CWAS_VLIM_RST;
      pend_q <= 8'h00;
      pend_ofs_q <= 8'h00;
      pend_v_q <= 1'b0;
      wdt_q <= 64'd0;
    end else begin
      if (pend_v_q) wdt_q <= wdt_q + 64'd1;
      if (pend_v_q && wdt_q >= wdt_lim) pend_v_q <= 1'b0;
      if (wr_stb) begin
        if (wr_ofs == CWAS_OFS_OPT0_L) opt0_q[7:0] <= wr_dat;
        else if (wr_ofs == CWAS_OFS_OPT0_H) opt0_q[15:8] <= wr_dat;
        else if (wr_ofs == CWAS_OFS_ICHG_L ||
                 wr_ofs == CWAS_OFS_VLIM_L) begin
          pend_q <= wr_dat;
          pend_ofs_q <= wr_ofs;
          pend_v_q <= 1'b1;
          wdt_q <= 64'd0;
        end else if (pend_v_q && wdt_q < wdt_lim &&
                     wr_ofs == pend_ofs_q + 8'd1) begin
          if (wr_ofs == CWAS_OFS_ICHG_H) ichg_q <= {wr_dat, pend_q};
          if (wr_ofs == CWAS_OFS_VLIM_H) vlim_q <= {wr_dat, pend_q};
          pend_v_q <= 1'b0;
        end else pend_v_q <= 1'b0;
      end
    end
  end

  assign CHARGE_CURRENT = ichg_q;
  assign VOLTAGE_LIMIT  = vlim_q;
  assign BUS_BUSY       = busy_q;
endmodule // cwas_dev

// file: logic/cwas_host.sv
// host end: AXI4-Lite commanded two-wire master for word access
`timescale 1ns/10ps
module cwas_host
  import cwas_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  cwas_if.host             BUS,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  // command word: [7:0] register, [15:8] low data, [23:16] high data,
  // [24] read, [25] go; every frame writes two data bytes, the read bit is stored but does not change the frame
  typedef enum logic [1:0] {
    CWAS_H_IDLE = 2'b00,
    CWAS_H_RUN  = 2'b01
  } cwas_hstate_t;

  cwas_hstate_t st_q;
  logic [15:0] div_q, cnt_q;
  logic [1:0]  qtr_q;
  logic [5:0]  seq_q;
  logic [36:0] tx_q;
  logic [15:0] rx_q;
  logic        rd_q, nack_q, scl_q, sda_q, sda_stall_q;
  logic        aw_q, w_q;
  logic [3:0]  awa_q;
  logic [31:0] wd_q;
  logic [1:0]  scl_s_q, sda_s_q;

  // pins come from outside: two flops before use
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
    end else begin
      scl_s_q <= {scl_s_q[0], BUS.scl};
      sda_s_q <= {sda_s_q[0], BUS.sda};
    end
  end

  // axi write channels taken independently, response after both
  assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_q && !S_AXI_BVALID;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      S_AXI_BVALID <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q <= 1'b1;
        awa_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q <= 1'b1;
        wd_q <= S_AXI_WDATA;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
      end else if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
    end
  end
  assign S_AXI_BRESP = 2'b00;

  logic go;
  assign go = aw_q && w_q && awa_q == CWAS_AX_CMD && wd_q[25] &&
              st_q == CWAS_H_IDLE;

  // host makes every clock pulse, ack included
  // frame sequencer: one bit per four quarter periods
  // byte layout: start, addr, reg, d0, d1, stop
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= CWAS_H_IDLE;
      div_q <= CWAS_DIV_RST;
      cnt_q <= 16'd0;
      qtr_q <= 2'd0;
      seq_q <= 6'd0;
      tx_q <= 37'd0;
      rx_q <= 16'd0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_stall_q <= 1'b0;
    end else begin
      if (aw_q && w_q && awa_q == CWAS_AX_DIV && st_q == CWAS_H_IDLE)
        div_q <= (wd_q[15:0] == 16'd0) ? 16'd1 : wd_q[15:0];
      case (st_q)
        CWAS_H_IDLE: begin
          if (go) begin
            st_q <= CWAS_H_RUN;
            rd_q <= wd_q[24];
            nack_q <= 1'b0;
            // four bytes with ack slots, then a low bit for the stop
            tx_q <= {CWAS_ADDR7, 1'b0, 1'b1, wd_q[7:0], 1'b1,
                     wd_q[15:8], 1'b1, wd_q[23:16], 1'b1, 1'b0};
            seq_q <= 6'd0;
            qtr_q <= 2'd0;
            cnt_q <= 16'd0;
            sda_q <= 1'b0;
          end
        end
        CWAS_H_RUN: begin
          // clock stretching: hold count while scl is held low
          sda_stall_q <= scl_q && !scl_s_q[1];
          if (!(scl_q && !scl_s_q[1])) begin
            if (cnt_q + 16'd1 >= div_q) begin
              cnt_q <= 16'd0;
              qtr_q <= qtr_q + 2'd1;
              if (qtr_q == 2'd0) scl_q <= 1'b0;
              if (qtr_q == 2'd1) begin
                sda_q <= tx_q[36];
                tx_q <= {tx_q[35:0], 1'b1};
              end
              if (qtr_q == 2'd2) scl_q <= 1'b1;
              if (qtr_q == 2'd3) begin
                seq_q <= seq_q + 6'd1;
                if (seq_q[3:0] != 4'd0 || seq_q == 6'd0)
                  rx_q <= {rx_q[14:0], sda_s_q[1]};
                if (seq_q == 6'd8 || seq_q == 6'd17) nack_q <= nack_q ||
                                                        sda_s_q[1];
                // stop: data rises while clock high
                if (seq_q == 6'd36) begin
                  st_q <= CWAS_H_IDLE;
                  sda_q <= 1'b1;
                end
              end
            end else cnt_q <= cnt_q + 16'd1;
          end
        end
        default: st_q <= CWAS_H_IDLE;
      endcase
    end
  end

  assign BUS.scl_o_host  = 1'b0;
  assign BUS.scl_oe_host = !scl_q;
  assign BUS.sda_o_host  = 1'b0;
  assign BUS.sda_oe_host = !sda_q;

  // axi read: status and received data
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= 2'b00;
      if (S_AXI_ARADDR == CWAS_AX_STAT)
        S_AXI_RDATA <= {29'd0, sda_stall_q, nack_q, st_q == CWAS_H_RUN};
      else if (S_AXI_ARADDR == CWAS_AX_RDAT)
        S_AXI_RDATA <= {16'd0, rx_q};
      else if (S_AXI_ARADDR == CWAS_AX_DIV)
        S_AXI_RDATA <= {16'd0, div_q};
      else if (S_AXI_ARADDR == CWAS_AX_CMD)
        S_AXI_RDATA <= 32'h0;
      else begin
        S_AXI_RDATA <= 32'h0;
        S_AXI_RRESP <= 2'b10;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) S_AXI_RVALID <= 1'b0;
  end
endmodule // cwas_host

// file: dv/cwas_link_props.sv
// properties of the two-wire link between host and device ends
`timescale 1ns/10ps
module cwas_link_props
  import cwas_pkg::*;
(
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic scl_o_dev,
  input  wire logic scl_oe_dev,
  input  wire logic sda_o_dev,
  input  wire logic sda_oe_dev,
  input  wire logic BUS_BUSY
);
  logic       scl_q;
  logic       sda_q;
  logic       nak_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic       start_ev;
  logic       stop_ev;
  logic       rise;

  // wire events against one cycle of history
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign rise     = scl && !scl_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // bit, byte and shifted byte of the frame; restarts on every start
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      nak_q  <= 1'b0;
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
      sh_q   <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        bit_q  <= 4'h0;
        byte_q <= 2'h0;
        nak_q  <= 1'b0;
      end else if (rise) begin
        bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
        if (bit_q == 4'h9 && byte_q != 2'h3) begin
          byte_q <= byte_q + 2'h1;
        end
        // the ninth bit is not part of the byte
        if (bit_q != 4'h8) begin
          sh_q <= {sh_q[6:0], sda};
        end
        if (bit_q == 4'h8 && sda) begin
          nak_q <= 1'b1;
        end
      end
    end
  end

  a_pins_open_drain: assert property (
    (sda_oe_dev -> !sda_o_dev) && (scl_oe_dev -> !scl_o_dev))
    else $error("device drives a line high");
  a_data_stable: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("device data changed while clock high");
  a_start_busy: assert property (start_ev |-> ##[1:8] BUS_BUSY)
    else $error("start not reported as busy");
  a_stop_idle: assert property (stop_ev |-> ##[1:8] !BUS_BUSY)
    else $error("stop not reported as idle");
  a_idle_quiet: assert property (!BUS_BUSY |-> !sda_oe_dev)
    else $error("device drives data on an idle bus");
  a_ack_held: assert property (
    $rose(scl) && sda_oe_dev |-> sda_oe_dev [*8])
    else $error("acknowledge released during clock high");
  a_ack_slot: assert property (scl && scl_q && sda_oe_dev |->
    bit_q == 4'h9) else $error("device pulls data outside ninth bit");
  a_addr_match: assert property (scl && scl_q && sda_oe_dev &&
    byte_q == 2'h0 |-> sh_q[7:1] == CWAS_ADDR7)
    else $error("foreign address acknowledged");
  a_reg_defined: assert property (scl && scl_q && sda_oe_dev &&
    byte_q == 2'h1 |-> sh_q <= CWAS_OFS_VLIM_H || sh_q == CWAS_OFS_MAKER ||
    sh_q == CWAS_OFS_PART) else $error("undefined register acknowledged");
  a_nack_idle: assert property (nak_q |-> !sda_oe_dev)
    else $error("device drives data after a refusal");
endmodule // cwas_link_props

// file: dv/charger_i2c_word_access_slave_bench.sv
// self-checking bench: host and device ends joined over the two-wire bus
`timescale 1ns/10ps
module charger_i2c_word_access_slave_bench
  import cwas_pkg::*;
;
  localparam longint WDT   = 4000;
  localparam int     LIMIT = 60000;
  logic        clk_sys, rst_n, busy;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, stat;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [15:0] chg, vlim, lfsr, ev_chg, ev_vlim;
  int          mismatches, checks;
  int          cycles = 0;

  cwas_if bus ();
  cwas_host i_cwas_host (.CLK_SYS(clk_sys), .RST_N(rst_n), .BUS(bus),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  cwas_dev #(.WDT_CYCLES(WDT)) i_cwas_dev (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .BUS(bus), .CHARGE_CURRENT(chg), .VOLTAGE_LIMIT(vlim), .BUS_BUSY(busy));
  cwas_link_props i_props (.CLK_SYS(clk_sys), .RST_N(rst_n), .scl(bus.scl),
    .sda(bus.sda), .scl_o_dev(bus.scl_o_dev), .scl_oe_dev(bus.scl_oe_dev),
    .sda_o_dev(bus.sda_o_dev), .sda_oe_dev(bus.sda_oe_dev),
    .BUS_BUSY(busy));

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  // cut a hang short; frames are long, so the ceiling is generous
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // a word is low byte at the even offset, high byte above it
  function automatic logic [15:0] exp_word(input logic [7:0] lo, hi);
    return {hi, lo};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_ok = aw_ok || awready;
      w_ok  = w_ok || wready;
    end while (!(aw_ok && w_ok));
    while (!bvalid) @(posedge clk_sys);
    bready <= 1'b0;
    chk_resp(bresp, 2'b00);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk_sys);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // one host frame: start, address, register, two bytes, stop
  task automatic frame(input logic [7:0] rg, lo, hi);
    logic [1:0] r;
    axi_wr(CWAS_AX_CMD, {8'h02, hi, lo, rg});
    do axi_rd(CWAS_AX_STAT, stat, r); while (!stat[0]);
    do axi_rd(CWAS_AX_STAT, stat, r); while (stat[0]);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  pend;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb      = 4'hF;
    mismatches = 0;
    checks     = 0;
    lfsr       = 16'h000D;
    ev_chg     = CWAS_ICHG_RST;
    ev_vlim    = CWAS_VLIM_RST;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk_data({chg, vlim}, {ev_chg, ev_vlim});
    chk_data({31'h0, busy}, 32'h00000000);
    axi_rd(CWAS_AX_DIV, d, r);
    chk_data(d, {16'h0000, CWAS_DIV_RST});
    axi_rd(4'h2, d, r);
    chk_resp(r, 2'b10);
    axi_wr(CWAS_AX_DIV, 32'h00000008);
    axi_rd(CWAS_AX_DIV, d, r);
    chk_data(d, 32'h00000008);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      d[15:0] = (i == 0) ? 16'hFF00 : (i == 1) ? 16'h00FF : lfsr;
      frame(CWAS_OFS_ICHG_L, d[7:0], d[15:8]);
      ev_chg = exp_word(d[7:0], d[15:8]);
      chk_data({chg, vlim}, {ev_chg, ev_vlim});
      chk_resp(stat[2:1], 2'b00);
    end
    $display("test word write done");
    // lone high byte ignored, next low byte held
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_ICHG_H, lfsr[7:0], lfsr[15:8]);
    chk_data({chg, vlim}, {ev_chg, ev_vlim});
    pend = lfsr[15:8];
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_VLIM_H, lfsr[7:0], lfsr[15:8]);
    ev_vlim = exp_word(pend, lfsr[7:0]);
    chk_data({chg, vlim}, {ev_chg, ev_vlim});
    $display("test pointer done");
    frame(8'h10, 8'hAA, 8'h55);
    chk_resp(stat[2:1], 2'b01);
    chk_data({chg, vlim}, {ev_chg, ev_vlim});
    $display("test refusal done");
    // shortest watchdog option drops a slow pair
    frame(CWAS_OFS_OPT0_L, CWAS_OPT0_RST[7:0],
          (CWAS_OPT0_RST[15:8] & 8'h9F) | 8'h20);
    chk_resp(stat[2:1], 2'b00);
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_ICHG_H, lfsr[7:0], lfsr[15:8]);
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_VLIM_H, lfsr[7:0], lfsr[15:8]);
    chk_data({16'h0000, vlim}, {16'h0000, ev_vlim});
    frame(CWAS_OFS_OPT0_L, CWAS_OPT0_RST[7:0], CWAS_OPT0_RST[15:8]);
    chk_resp(stat[2:1], 2'b00);
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_ICHG_H, lfsr[7:0], lfsr[15:8]);
    pend = lfsr[15:8];
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_VLIM_H, lfsr[7:0], lfsr[15:8]);
    ev_vlim = exp_word(pend, lfsr[7:0]);
    chk_data({16'h0000, vlim}, {16'h0000, ev_vlim});
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_ICHG_H, lfsr[7:0], lfsr[15:8]);
    repeat (WDT + 1000) @(posedge clk_sys);
    lfsr = lfsr_next(lfsr);
    frame(CWAS_OFS_VLIM_H, lfsr[7:0], lfsr[15:8]);
    chk_data({16'h0000, vlim}, {16'h0000, ev_vlim});
    $display("test watchdog done");
    stop_test();
  end
endmodule // charger_i2c_word_access_slave_bench
